// *** rtl/tcmo_timer.sv ***
// 16-bit timer counter with two compare channels and their output stage.
// Assumes a register master on sys_clk and port logic that owns pin direction.
//
// Behaviour
// - Channel mode bits choose waveform bit action at the next match.
// - Reset clears each waveform bit to zero, separate from the pin.
// - Nonzero mode bits make waveform bit replace port output value.
// - Port direction bit still decides whether the pin is driven.
// - Waveform bit may be preset before the pin driver is enabled.
// - Mode bits never touch input capture.
// - Mode zero leaves waveform bit unchanged at matches.
// - New mode bits act from the first match after the write.
// - Force strobe applies the configured action at once in non-PWM modes.
// - Counting depends on generation mode bits, not on channel mode bits.
// - Non-PWM mode bits set, clear or toggle the waveform bit.
// - PWM mode bits pick inverted or non-inverted polarity.
// - Mode zero always increments, never cleared by a match.
// - Normal mode wraps from maximum to zero and continues.
// - Overflow flag sets in the cycle the count becomes zero.
// - Counting only sets overflow flag; servicing clears it.
// - Count accepts software writes at any time.
// - Normal mode still detects matches and raises flags.
// - Forced compare updates output only, no flag, no counter change.
// - Any count write blocks a match in the next cycle.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "tcmo_defs.svh"

module tcmo_timer #(
    parameter int CHANNELS = 2
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // Register port
    input  wire tcmo_pkg::tcmo_req_t reg_req,
    output logic [15:0]              reg_rdata,
    // Port logic side
    input  wire logic [CHANNELS-1:0] port_out_val,
    input  wire logic [CHANNELS-1:0] wave_pin_dir,
    output logic [CHANNELS-1:0]      pin_out,
    output logic [CHANNELS-1:0]      pin_oe_n,
    // Service and status
    input  wire logic                ovf_serviced,
    output logic                     overflow_flag,
    output logic [CHANNELS-1:0]      cmp_match_flag
);
    import tcmo_pkg::*;

    // ======================================================================
    // Registers
    logic                run;
    logic [3:0]          wavegen_mode_sel;
    logic [1:0]          cmp_out_mode [CHANNELS];
    logic [15:0]         count_value;
    logic [15:0]         cmp_value_reg [CHANNELS];
    logic [CHANNELS-1:0] wave_out_bit;
    logic                match_block;

    // ======================================================================
    // Decode
    wire wr_ctrl   = reg_req.wr && (reg_req.addr == `TCMO_ADDR_CTRL);
    wire wr_count  = reg_req.wr && (reg_req.addr == `TCMO_ADDR_COUNT);
    wire wr_status = reg_req.wr && (reg_req.addr == `TCMO_ADDR_STATUS);
    wire wr_force  = reg_req.wr && (reg_req.addr == `TCMO_ADDR_FORCE);
    // PWM modes are all except normal and the two clear-on-match modes
    wire is_pwm    = (wavegen_mode_sel != `TCMO_WGM_NORMAL) &&
                     (wavegen_mode_sel != `TCMO_WGM_CTC_A) &&
                     (wavegen_mode_sel != `TCMO_WGM_CTC_I);
    wire is_ctc    = (wavegen_mode_sel == `TCMO_WGM_CTC_A) ||
                     (wavegen_mode_sel == `TCMO_WGM_CTC_I);
    // Channel A compare defines the top in clear-on-match mode
    wire ctc_clear = is_ctc && run && (count_value == cmp_value_reg[0]) && !match_block;
    wire at_max    = (count_value == `TCMO_COUNT_MAX);

    // ======================================================================
    // Counter; mode bits of channels play no part here
    logic [15:0] next_count;
    assign next_count = wr_count  ? reg_req.wdata :
                        ctc_clear ? `TCMO_COUNT_ZERO :
                        run       ? 16'(count_value + 16'h0001) :
                                    count_value;
    wire ovf_event = run && !wr_count && !ctc_clear && at_max;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= `TCMO_COUNT_ZERO;
            match_block <= 1'b0;
        end else begin
            count_value <= next_count;
            match_block <= wr_count;
        end
    end

    // Overflow flag: set wins over clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else if (ovf_event) begin
            overflow_flag <= 1'b1;
        end else if (ovf_serviced || (wr_status && reg_req.wdata[`TCMO_STAT_OVF])) begin
            overflow_flag <= 1'b0;
        end
    end

    // ======================================================================
    // Control register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run              <= 1'b0;
            wavegen_mode_sel <= `TCMO_WGM_NORMAL;
        end else if (wr_ctrl) begin
            run              <= reg_req.wdata[`TCMO_CTRL_RUN];
            wavegen_mode_sel <= reg_req.wdata[`TCMO_CTRL_WGM_HI:`TCMO_CTRL_WGM_LO];
        end
    end

    // ======================================================================
    // Compare channels
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            localparam logic [3:0] CMP_ADDR = 4'(`TCMO_ADDR_CMP_A + ch);
            localparam int         COM_LO   = `TCMO_CTRL_COMA_LO + 2 * ch;
            // Matches only count while running; a count write masks one cycle
            wire match   = run && !match_block &&
                           (count_value == cmp_value_reg[ch]);
            wire forced  = wr_force && reg_req.wdata[ch] && !is_pwm;
            wire [1:0] m = cmp_out_mode[ch];
            logic next_wave;
            // Non-PWM actions; mode zero leaves the bit alone
            always_comb begin
                next_wave = wave_out_bit[ch];
                if (!is_pwm && (match || forced)) begin
                    case (m)
                        `TCMO_COM_TOGGLE: next_wave = ~wave_out_bit[ch];
                        `TCMO_COM_CLEAR:  next_wave = 1'b0;
                        `TCMO_COM_SET:    next_wave = 1'b1;
                        default:          next_wave = wave_out_bit[ch];
                    endcase
                end else if (is_pwm && m[1]) begin
                    // Mode 2 non-inverted, 3 inverted: match drives, wrap restores
                    if (match) begin
                        next_wave = m[0];
                    end else if (ovf_event) begin
                        next_wave = ~m[0];
                    end
                end
            end
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    wave_out_bit[ch]   <= 1'b0;
                    cmp_out_mode[ch]   <= `TCMO_COM_OFF;
                    cmp_value_reg[ch]  <= `TCMO_COUNT_ZERO;
                    cmp_match_flag[ch] <= 1'b0;
                    pin_out[ch]        <= 1'b0;
                    pin_oe_n[ch]       <= 1'b1;
                end else begin
                    // Preset via forced compare while pin still input
                    wave_out_bit[ch] <= next_wave;
                    // Mode stored now, consulted at later matches and by the pin override select
                    if (wr_ctrl) begin
                        cmp_out_mode[ch] <= reg_req.wdata[COM_LO+1:COM_LO];
                    end
                    if (reg_req.wr && reg_req.addr == CMP_ADDR) begin
                        cmp_value_reg[ch] <= reg_req.wdata;
                    end
                    if (match) begin
                        cmp_match_flag[ch] <= 1'b1;
                    end else if (wr_status && reg_req.wdata[`TCMO_STAT_CMPA + ch]) begin
                        cmp_match_flag[ch] <= 1'b0;
                    end
                    // Override of the port value; direction stays with port
                    pin_out[ch]  <= (m != `TCMO_COM_OFF) ? next_wave
                                                         : port_out_val[ch];
                    pin_oe_n[ch] <= ~wave_pin_dir[ch];
                end
            end
        end
    endgenerate

    // ======================================================================
    // Read-back
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        case (reg_req.addr)
            `TCMO_ADDR_CTRL: begin
                rd_mux[`TCMO_CTRL_RUN]                         = run;
                rd_mux[`TCMO_CTRL_WGM_HI:`TCMO_CTRL_WGM_LO]    = wavegen_mode_sel;
                rd_mux[`TCMO_CTRL_COMA_HI:`TCMO_CTRL_COMA_LO]  = cmp_out_mode[0];
                rd_mux[`TCMO_CTRL_COMB_HI:`TCMO_CTRL_COMB_LO]  = cmp_out_mode[1];
            end
            `TCMO_ADDR_COUNT:  rd_mux = count_value;
            `TCMO_ADDR_CMP_A:  rd_mux = cmp_value_reg[0];
            `TCMO_ADDR_CMP_B:  rd_mux = cmp_value_reg[1];
            `TCMO_ADDR_STATUS: begin
                rd_mux[`TCMO_STAT_OVF]   = overflow_flag;
                rd_mux[`TCMO_STAT_CMPA]  = cmp_match_flag[0];
                rd_mux[`TCMO_STAT_CMPB]  = cmp_match_flag[1];
                rd_mux[`TCMO_STAT_WAVEA] = wave_out_bit[0];
                rd_mux[`TCMO_STAT_WAVEB] = wave_out_bit[1];
            end
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_req.rd ? rd_mux : 16'h0000;
        end
    end

endmodule // tcmo_timer

// *** common/tcmo_defs.svh ***
// Constants for the 16-bit timer compare-output stage.
// Assumes inclusion by the design file, checker and bench by bare name.
`ifndef TCMO_DEFS_SVH
`define TCMO_DEFS_SVH

// ==========================================================================
// Register offsets (word index on the plain register port)
`define TCMO_ADDR_CTRL      4'h0
`define TCMO_ADDR_COUNT     4'h1
`define TCMO_ADDR_CMP_A     4'h2
`define TCMO_ADDR_CMP_B     4'h3
`define TCMO_ADDR_STATUS    4'h4
`define TCMO_ADDR_FORCE     4'h5

// ==========================================================================
// Control field positions
`define TCMO_CTRL_RUN       0
`define TCMO_CTRL_WGM_LO    1
`define TCMO_CTRL_WGM_HI    4
`define TCMO_CTRL_COMA_LO   5
`define TCMO_CTRL_COMA_HI   6
`define TCMO_CTRL_COMB_LO   7
`define TCMO_CTRL_COMB_HI   8

// Status field positions; a one written clears a flag
`define TCMO_STAT_OVF       0
`define TCMO_STAT_CMPA      1
`define TCMO_STAT_CMPB      2
`define TCMO_STAT_WAVEA     3
`define TCMO_STAT_WAVEB     4

// ==========================================================================
// Reset values and counts
`define TCMO_COUNT_MAX      16'hFFFF
`define TCMO_COUNT_ZERO     16'h0000
`define TCMO_WGM_NORMAL     4'h0
`define TCMO_WGM_CTC_A      4'h4
`define TCMO_WGM_CTC_I      4'hC
`define TCMO_COM_OFF        2'h0
`define TCMO_COM_TOGGLE     2'h1
`define TCMO_COM_CLEAR      2'h2
`define TCMO_COM_SET        2'h3

`endif

// *** common/tcmo_pkg.sv ***
// Types for the 16-bit timer compare-output stage.
// Assumes no constants from the header; it includes nothing.
package tcmo_pkg;

    // ======================================================================
    // Per-channel pin view handed to the port logic
    typedef struct packed {
        logic wave_out_bit;
        logic override_en;
    } tcmo_pin_t;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } tcmo_req_t;

endpackage

// *** verification/tcmo_checker.sv ***
// Port-level assertions for the timer compare-output stage.
// Assumes binding to tcmo_timer; shadows registers from bus writes, normal mode only.
`timescale 1ns/1ps
`include "tcmo_defs.svh"
module tcmo_checker #(
    parameter int CHANNELS = 2
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // Register port
    input  wire tcmo_pkg::tcmo_req_t reg_req,
    input  wire logic [15:0]         reg_rdata,
    // Port side
    input  wire logic [CHANNELS-1:0] port_out_val,
    input  wire logic [CHANNELS-1:0] wave_pin_dir,
    input  wire logic [CHANNELS-1:0] pin_out,
    input  wire logic [CHANNELS-1:0] pin_oe_n,
    // Status
    input  wire logic                ovf_serviced,
    input  wire logic                overflow_flag,
    input  wire logic [CHANNELS-1:0] cmp_match_flag
);
    import tcmo_pkg::*;
    logic [15:0] ctrl;
    logic [15:0] cnt;
    logic [15:0] cmpa;
    logic        wblk;
    wire         wr_cnt = reg_req.wr && reg_req.addr == `TCMO_ADDR_COUNT;
    wire         clr_st = reg_req.wr && reg_req.addr == `TCMO_ADDR_STATUS;
    wire         frc    = reg_req.wr && reg_req.addr == `TCMO_ADDR_FORCE;
    wire         run    = ctrl[0] && ctrl[4:1] == `TCMO_WGM_NORMAL;
    wire         hit_a  = run && !wblk && cnt == cmpa;
    // ======================================================================
    // Shadows; a count write wins over counting
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= 16'h0000;
            cnt  <= 16'h0000;
            cmpa <= 16'h0000;
            wblk <= 1'b0;
        end else begin
            if (reg_req.wr && reg_req.addr == `TCMO_ADDR_CTRL) ctrl <= reg_req.wdata;
            if (reg_req.wr && reg_req.addr == `TCMO_ADDR_CMP_A) cmpa <= reg_req.wdata;
            if (wr_cnt) cnt <= reg_req.wdata;
            else if (run) cnt <= cnt + 16'h0001;
            wblk <= wr_cnt;
        end
    end
    // ======================================================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_oe; rst_n |=> pin_oe_n == ~$past(wave_pin_dir); endproperty
    property p_pass; rst_n && ctrl[6:5] == 2'h0 |=> pin_out[0] == $past(port_out_val[0]);
    endproperty
    property p_ovf_set; run && cnt == 16'hFFFF && !wr_cnt |=> overflow_flag; endproperty
    property p_ovf_hold;
        overflow_flag && !ovf_serviced && !(clr_st && reg_req.wdata[0]) |=> overflow_flag;
    endproperty
    property p_match; hit_a |=> cmp_match_flag[0]; endproperty
    property p_block; wblk && cnt == cmpa && !cmp_match_flag[0] |=> !cmp_match_flag[0];
    endproperty
    property p_force; frc && !hit_a && !cmp_match_flag[0] |=> !cmp_match_flag[0]; endproperty
    property p_cmp_hold; cmp_match_flag[0] && !clr_st |=> cmp_match_flag[0]; endproperty
    a_oe: assert property (p_oe) else $error("oe not tracking direction");
    a_pass: assert property (p_pass) else $error("port value not passed");
    a_ovf_set: assert property (p_ovf_set) else $error("no overflow flag");
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
    a_match: assert property (p_match) else $error("match missed");
    a_block: assert property (p_block) else $error("match not blocked");
    a_force: assert property (p_force) else $error("force set a flag");
    a_cmp_hold: assert property (p_cmp_hold) else $error("match flag lost");
    c_ovf: cover property ($rose(overflow_flag));
    c_match: cover property (hit_a);
    c_force: cover property (frc);
endmodule // tcmo_checker

// *** verification/tcmo_port_model.sv ***
// Port pin model: general output value, direction bit and the pad.
// Assumes the bench sets the wanted port value and direction.
`timescale 1ns/1ps
module tcmo_port_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Bench side
    input  wire logic [1:0] set_val,
    input  wire logic [1:0] set_dir,
    // Timer side
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe_n,
    output logic      [1:0] port_out_val,
    output logic      [1:0] wave_pin_dir,
    output logic      [1:0] pad
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_out_val <= 2'b00;
            wave_pin_dir <= 2'b00;
        end else begin
            port_out_val <= set_val;
            wave_pin_dir <= set_dir;
        end
    end
    // Undriven pad floats high through the pull-up
    assign pad = pin_out | pin_oe_n;
endmodule // tcmo_port_model

// *** verification/tcmo_timer_bench.sv ***
// Self-checking bench for the timer compare-output stage.
// Assumes checker and port model compiled first; one 10 MHz clock.
`timescale 1ns/1ps
`include "tcmo_defs.svh"
module tcmo_timer_bench;
    import tcmo_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ovf_serviced = 1'b0;
    logic [1:0]  set_val = 2'b00;
    logic [1:0]  set_dir = 2'b00;
    tcmo_req_t   req = '0;
    logic [15:0] reg_rdata;
    logic [1:0]  port_out_val, wave_pin_dir, pin_out, pin_oe_n, pad, cmp_match_flag;
    logic        overflow_flag;
    logic        wave_a = 1'b0;
    int          error_cnt = 0;
    int          checks = 0;
    tcmo_timer tcmo_timer_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req),
        .reg_rdata(reg_rdata), .port_out_val(port_out_val), .wave_pin_dir(wave_pin_dir),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ovf_serviced(ovf_serviced),
        .overflow_flag(overflow_flag), .cmp_match_flag(cmp_match_flag));
    tcmo_port_model tcmo_port_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .set_val(set_val),
        .set_dir(set_dir), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pad(pad),
        .port_out_val(port_out_val), .wave_pin_dir(wave_pin_dir));
    // ======================================================================
    // Shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask
    task automatic test_done;
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ======================================================================
    // Scenarios
    task automatic t_reset;
        for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0000);
        chk(pin_oe_n, 2'b11);
    endtask
    task automatic t_pass;
        @(posedge sys_clk);
        set_val <= 2'b10;
        set_dir <= 2'b11;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(pin_out, 2'b10);
        chk(pad, 2'b10);
        @(posedge sys_clk);
        set_dir <= 2'b00;
    endtask
    task automatic t_force;
        logic [1:0] m;
        for (int i = 3; i >= 0; i--) begin
            m = i[1:0];
            wr(`TCMO_ADDR_CTRL, {9'h000, m, 5'h00});
            wr(`TCMO_ADDR_FORCE, 16'h0001);
            if (m != `TCMO_COM_OFF) wave_a = (m == `TCMO_COM_TOGGLE) ? ~wave_a : m[0];
            rd(`TCMO_ADDR_STATUS, {12'h000, wave_a, 3'b000});
            if (m != `TCMO_COM_OFF) chk(pin_out[0], wave_a);
            chk(pad[0], 1'b1);
        end
        rd(`TCMO_ADDR_COUNT, 16'h0000);
    endtask
    task automatic t_match;
        wr(`TCMO_ADDR_CMP_A, 16'h0005);
        wr(`TCMO_ADDR_CMP_B, 16'h0005);
        wr(`TCMO_ADDR_COUNT, 16'h0000);
        wr(`TCMO_ADDR_CTRL, 16'h0021);
        set_dir <= 2'b01;
        repeat (8) @(posedge sys_clk);
        wave_a = ~wave_a;
        rd(`TCMO_ADDR_STATUS, {12'h000, wave_a, 3'b110});
        chk(cmp_match_flag, 2'b11);
        chk(pad[0], wave_a);
        // Match at five must not clear the count in mode zero
        rd(`TCMO_ADDR_COUNT, 16'h000B);
    endtask
    task automatic t_block;
        wr(`TCMO_ADDR_STATUS, 16'h0007);
        wr(`TCMO_ADDR_COUNT, 16'h0005);
        repeat (4) @(posedge sys_clk);
        rd(`TCMO_ADDR_STATUS, {12'h000, wave_a, 3'b000});
    endtask
    // PWM mode 5: A non-inverted, B inverted; count resynced to the checker after
    task automatic t_pwm;
        wr(`TCMO_ADDR_CTRL, 16'h01CA);
        wr(`TCMO_ADDR_FORCE, 16'h0003);
        rd(`TCMO_ADDR_STATUS, 16'h0000);
        wr(`TCMO_ADDR_COUNT, 16'h0004);
        wr(`TCMO_ADDR_CTRL, 16'h01CB);
        repeat (2) @(posedge sys_clk);
        rd(`TCMO_ADDR_STATUS, 16'h0016);
        chk(pin_out, 2'b10);
        wr(`TCMO_ADDR_COUNT, 16'hFFFE);
        repeat (2) @(posedge sys_clk);
        rd(`TCMO_ADDR_STATUS, 16'h000F);
        chk(pad, 2'b11);
        wr(`TCMO_ADDR_CTRL, 16'h0020);
        wr(`TCMO_ADDR_COUNT, 16'h0010);
        wr(`TCMO_ADDR_STATUS, 16'h0007);
        wr(`TCMO_ADDR_CTRL, 16'h0021);
    endtask
    task automatic t_ovf;
        wr(`TCMO_ADDR_COUNT, 16'hFFFE);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(overflow_flag, 1'b0);
        @(posedge sys_clk);
        #1;
        chk(overflow_flag, 1'b1);
        rd(`TCMO_ADDR_COUNT, 16'h0001);
        @(posedge sys_clk);
        ovf_serviced <= 1'b1;
        @(posedge sys_clk);
        ovf_serviced <= 1'b0;
        @(negedge sys_clk);
        chk(overflow_flag, 1'b0);
    endtask
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_pass();
        t_force();
        t_match();
        t_block();
        t_pwm();
        t_ovf();
        test_done();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        test_done();
    end
endmodule // tcmo_timer_bench
bind tcmo_timer tcmo_checker #(.CHANNELS(CHANNELS)) tcmo_checker_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .port_out_val(port_out_val),
    .wave_pin_dir(wave_pin_dir), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ovf_serviced(ovf_serviced), .overflow_flag(overflow_flag),
    .cmp_match_flag(cmp_match_flag));
